/* verilog/cmu_conditional_move_unit.sv */
// conditional move decoder and executor with avalon control registers
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps

module cmu_conditional_move_unit (
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire cmu_pkg::cmu_issue_t issue,
	output cmu_pkg::cmu_wb_t    wb,
	input  wire logic [7:0]     avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [31:0]    avs_writedata,
	output logic [31:0]         avs_readdata,
	output logic                avs_waitrequest
);
	import cmu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [3:0]  ctrl_r,   ctrl_nxt;
	logic [7:0]  ccode_r,  ccode_nxt;
	logic [31:0] instr_r,  instr_nxt;
	logic [31:0] stat_r,   stat_nxt;
	logic [31:0] rdata_r,  rdata_nxt;
	logic        ack_r,    ack_nxt;
	cmu_wb_t     wb_r,     wb_nxt;

	////////////////////////////////////////////////////////////////////////
	// decode
	logic [5:0]  opc, fn;
	logic [4:0]  fmt, src_f, tst_f, fs_f, fd_f;
	logic [2:0]  cc;
	logic        is_int_nz, is_fp_nz, is_int_t, is_fp_t, fmt_ok, is_paired;
	logic        rel6, fpu_on, fr_wide, fpu64;
	logic        cc_lo, cc_hi, test_nz;

	always_comb begin
		opc      = issue.word[OPC_LSB +: 6];
		fn       = issue.word[5:0];
		fmt      = issue.word[SRC_LSB +: 5];
		src_f    = issue.word[SRC_LSB +: 5];
		tst_f    = issue.word[TST_LSB +: 5];
		fs_f     = issue.word[FS_LSB +: 5];
		fd_f     = issue.word[FD_LSB +: 5];
		cc       = issue.word[CC_LSB +: 3];
		rel6     = ctrl_r[CTRL_R6_BIT];
		fpu_on   = ctrl_r[CTRL_FPU_EN];
		fr_wide  = ctrl_r[CTRL_FR_BIT];
		fpu64    = ctrl_r[CTRL_F64_BIT];
		fmt_ok   = (fmt == FMT_SINGLE) || (fmt == FMT_DOUBLE) || (fmt == FMT_PAIRED);
		is_paired = (fmt == FMT_PAIRED);
		is_int_nz = (opc == SPECIAL_OP) && (fn == FN_MOVE_NZ)
			&& (issue.word[FD_LSB +: 5] == SHAMT_ZERO);
		is_fp_nz  = (opc == FPU_MAJOR_OP) && (fn == FN_FP_MOVE_NZ);
		is_int_t  = (opc == SPECIAL_OP) && (fn == FN_MOVE_CF)
			&& issue.word[TF_BIT] && !issue.word[NDA_BIT];
		is_fp_t   = (opc == FPU_MAJOR_OP) && (fn == FN_FP_MOVE_CF)
			&& issue.word[TF_BIT] && !issue.word[NDA_BIT];
		test_nz  = (issue.test_gpr != 32'h00000000);
		// paired high half tests the neighbouring code; selector 7 wraps to 0
		cc_lo    = ccode_r[cc];
		cc_hi    = ccode_r[3'(cc + 3'h1)];
	end

	////////////////////////////////////////////////////////////////////////
	// execute
	always_comb begin
		wb_nxt       = '0;
		wb_nxt.exc   = EXC_NONE;
		wb_nxt.valid = issue.valid && (is_int_nz || is_fp_nz || is_int_t || is_fp_t);
		if (issue.valid && (is_int_nz || is_int_t)) begin
			// integer destination sits where the float source field lies
			wb_nxt.dest = fs_f;
			wb_nxt.data = {32'h00000000, issue.src_gpr};
			if (rel6) begin
				wb_nxt.exc = EXC_RESERVED;
			end else if (is_int_t && !fpu_on) begin
				wb_nxt.exc = EXC_COP_UNUSABLE;
			end else if (is_int_nz) begin
				wb_nxt.gpr_we = test_nz;
			end else begin
				wb_nxt.gpr_we = cc_lo;
			end
		end else if (issue.valid && (is_fp_nz || is_fp_t)) begin
			wb_nxt.dest = fd_f;
			// keeping the old destination value makes "not copied" a plain rewrite
			wb_nxt.data = issue.fd_val;
			if (!fpu_on) begin
				wb_nxt.exc = EXC_COP_UNUSABLE;
			end else if (rel6 || !fmt_ok) begin
				wb_nxt.exc = EXC_RESERVED;
			end else if (is_paired && !(fpu64 && fr_wide)) begin
				wb_nxt.exc = EXC_UNIMPL_OP;
				wb_nxt.undef = 1'b1;
			end else begin
				// no arithmetic flags are produced on any path here
				wb_nxt.fpr_we = 1'b1;
				wb_nxt.undef  = is_paired && cc[0];
				if (is_paired) begin
					if (is_fp_nz ? test_nz : cc_lo) begin
						wb_nxt.data[31:0] = issue.fs_val[31:0];
					end
					if (is_fp_nz ? test_nz : cc_hi) begin
						wb_nxt.data[63:32] = issue.fs_val[63:32];
					end
				end else if (is_fp_nz ? test_nz : cc_lo) begin
					wb_nxt.data = issue.fs_val;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer on the second edge
	always_comb begin
		ctrl_nxt  = ctrl_r;
		ccode_nxt = ccode_r;
		instr_nxt = instr_r;
		stat_nxt  = stat_r;
		rdata_nxt = rdata_r;
		ack_nxt   = 1'b0;
		if (wb_nxt.valid) begin
			instr_nxt = issue.word;
			stat_nxt  = {25'h0000000, wb_nxt.undef, wb_nxt.fpr_we, wb_nxt.gpr_we, 
				1'b1, wb_nxt.exc};
		end
		// write lands only at the edge that sees waitrequest low
		if (avs_write && ack_r) begin
			case (avs_address)
				REG_CTRL:  ctrl_nxt  = avs_writedata[3:0];
				REG_CCODE: ccode_nxt = avs_writedata[7:0];
				default:   ;
			endcase
		end
		if ((avs_read || avs_write) && !ack_r) begin
			ack_nxt = 1'b1;
			if (!avs_write) begin
				case (avs_address)
					REG_CTRL:      rdata_nxt = {28'h0000000, ctrl_r};
					REG_CCODE:     rdata_nxt = {24'h000000, ccode_r};
					REG_INSTR:     rdata_nxt = instr_r;
					REG_STATUS:    rdata_nxt = stat_r;
					REG_RESULT_LO: rdata_nxt = wb_r.data[31:0];
					REG_RESULT_HI: rdata_nxt = wb_r.data[63:32];
					default:       rdata_nxt = RD_UNMAPPED;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r  <= CTRL_RESET;
			ccode_r <= CCODE_RESET;
			instr_r <= 32'h00000000;
			stat_r  <= 32'h00000000;
			rdata_r <= 32'h00000000;
			ack_r   <= 1'b0;
			wb_r    <= '0;
		end else begin
			ctrl_r  <= ctrl_nxt;
			ccode_r <= ccode_nxt;
			instr_r <= instr_nxt;
			stat_r  <= stat_nxt;
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
			wb_r    <= wb_nxt;
		end
	end

	// waitrequest low only in the ack cycle; ack_r is a flip-flop
	always_comb begin
		avs_waitrequest = !ack_r;
		avs_readdata    = rdata_r;
		wb              = wb_r;
	end
endmodule : cmu_conditional_move_unit

/* verilog/cmu_pkg.sv */
// package: opcode fields, register map and carrier types of the conditional move unit
package cmu_pkg;
	localparam logic [5:0] SPECIAL_OP     = 6'h00;
	localparam logic [5:0] FPU_MAJOR_OP   = 6'h11;
	localparam logic [5:0] FN_MOVE_NZ     = 6'h0B;
	localparam logic [5:0] FN_FP_MOVE_NZ  = 6'h13;
	localparam logic [5:0] FN_MOVE_CF     = 6'h01;
	localparam logic [5:0] FN_FP_MOVE_CF  = 6'h11;
	localparam logic [4:0] SHAMT_ZERO     = 5'h00;
	localparam logic [4:0] FMT_SINGLE     = 5'h10;
	localparam logic [4:0] FMT_DOUBLE     = 5'h11;
	localparam logic [4:0] FMT_PAIRED     = 5'h16;
	localparam int         OPC_LSB        = 26;
	localparam int         SRC_LSB        = 21;
	localparam int         TST_LSB        = 16;
	localparam int         FS_LSB         = 11;
	localparam int         FD_LSB         = 6;
	localparam int         CC_LSB         = 18;
	localparam int         TF_BIT         = 16;
	localparam int         NDA_BIT        = 17;
	// avalon register map, word addresses shown as byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_CCODE      = 8'h04;
	localparam logic [7:0] REG_INSTR      = 8'h08;
	localparam logic [7:0] REG_STATUS     = 8'h0C;
	localparam logic [7:0] REG_RESULT_LO  = 8'h10;
	localparam logic [7:0] REG_RESULT_HI  = 8'h14;
	localparam int         CTRL_R6_BIT    = 0;
	localparam int         CTRL_FPU_EN    = 1;
	localparam int         CTRL_FR_BIT    = 2;
	localparam int         CTRL_F64_BIT   = 3;
	localparam logic [3:0] CTRL_RESET     = 4'hE;
	localparam logic [7:0] CCODE_RESET    = 8'h00;
	localparam logic [31:0] RD_UNMAPPED   = 32'h00000000;

	typedef enum logic [2:0] {
		EXC_NONE     = 3'h0,
		EXC_RESERVED = 3'h1,
		EXC_COP_UNUSABLE = 3'h2,
		EXC_UNIMPL_OP = 3'h3
	} cmu_exc_t;

	// one issued instruction with its register operands
	typedef struct packed {
		logic        valid;
		logic [31:0] word;
		logic [31:0] src_gpr;
		logic [31:0] test_gpr;
		logic [63:0] fs_val;
		logic [63:0] fd_val;
	} cmu_issue_t;

	// writeback towards the pipeline
	typedef struct packed {
		logic        valid;
		logic        gpr_we;
		logic        fpr_we;
		logic [4:0]  dest;
		logic [63:0] data;
		cmu_exc_t    exc;
		logic        undef;
	} cmu_wb_t;
endpackage : cmu_pkg

/* tb/cmu_props.sv */
// port checker of the conditional move unit
`timescale 1ns/10ps
module cmu_props (
	input wire logic                clk,
	input wire logic                rst,
	input wire cmu_pkg::cmu_issue_t issue,
	input wire cmu_pkg::cmu_wb_t    wb,
	input wire logic [7:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest
);
	import cmu_pkg::*;
	logic inz;
	logic fnz;
	logic tz;
	assign inz = issue.valid && issue.word[31:26] == SPECIAL_OP
		&& issue.word[5:0] == FN_MOVE_NZ;
	// paired form left out: its halves merge separately
	assign fnz = issue.valid && issue.word[31:26] == FPU_MAJOR_OP
		&& issue.word[5:0] == FN_FP_MOVE_NZ && issue.word[25:21] != FMT_PAIRED;
	assign tz = issue.test_gpr == 32'h00000000;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
	shamt_refused_a: assert property (inz && issue.word[10:6] != 5'h00 |=> !wb.valid)
		else $error("nonzero shift field accepted");
	int_zero_hold_a: assert property (inz && tz |=> !wb.gpr_we)
		else $error("integer move wrote on zero test");
	int_copy_src_a: assert property (inz && !tz |=> !wb.gpr_we || (wb.data[31:0] ==
		$past(issue.src_gpr) && wb.dest == $past(issue.word[15:11])))
		else $error("integer move data or destination wrong");
	fp_copy_src_a: assert property (fnz && !tz |=>
		!wb.fpr_we || wb.data == $past(issue.fs_val))
		else $error("float move did not copy source");
	fp_keep_old_a: assert property (fnz && tz |=>
		!wb.fpr_we || wb.data == $past(issue.fd_val))
		else $error("float move lost old destination");
	write_no_exc_a: assert property (wb.gpr_we || wb.fpr_we |-> wb.exc == EXC_NONE)
		else $error("write with exception");
	int_exc_limited_a: assert property (issue.valid && issue.word[31:26] == SPECIAL_OP
		|=> wb.exc != EXC_UNIMPL_OP) else $error("integer move raised float exception");
	avs_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
endmodule : cmu_props

bind cmu_conditional_move_unit cmu_props u_cmu_props (.clk(clk), .rst(rst), .issue(issue),
	.wb(wb), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));

/* tb/cmu_pipe_model.sv */
// pipeline stand-in presenting one instruction per request
`timescale 1ns/10ps
module cmu_pipe_model (
	input wire logic            go,
	input wire logic [31:0]     word,
	input wire logic [31:0]     src,
	input wire logic [31:0]     tst,
	input wire logic [63:0]     fsv,
	input wire logic [63:0]     fdv,
	output cmu_pkg::cmu_issue_t issue
);
	import cmu_pkg::*;
	// idle operands inverted so nothing leans on stale values
	always_comb begin
		issue = '{go, word, src, tst, fsv, fdv};
		if (!go)
			issue = '{1'b0, ~word, ~src, ~tst, ~fsv, ~fdv};
	end
endmodule : cmu_pipe_model

/* tb/tb_conditional_move_unit.sv */
// self-checking bench of the conditional move unit
`timescale 1ns/10ps
module tb_conditional_move_unit;
	import cmu_pkg::*;
	localparam logic [63:0] FS = 64'hA5A5A5A5_11112222;
	localparam logic [63:0] FD = 64'h5A5A5A5A_33334444;
	localparam logic [7:0]  CC = 8'h96;
	localparam logic [31:0] MNZ = {SPECIAL_OP, 15'h0443, SHAMT_ZERO, FN_MOVE_NZ};
	localparam logic [31:0] FNZ = {FPU_MAJOR_OP, FMT_SINGLE, 15'h0885, FN_FP_MOVE_NZ};
	logic clk = 0, rst = 1, go = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [7:0]  avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, word = 32'h0, src = 32'h0, tst = 32'h0, rd, avs_readdata;
	logic [63:0] fsv = 64'h0, fdv = 64'h0;
	cmu_issue_t  issue;
	cmu_wb_t     wb;
	int          err_count = 0, comparisons = 0, cycles = 0;
	always #5 clk = ~clk;
	cmu_pipe_model u_cmu_pipe_model (.go(go), .word(word), .src(src), .tst(tst), .fsv(fsv),
		.fdv(fdv), .issue(issue));
	cmu_conditional_move_unit u_cmu_conditional_move_unit (.clk(clk), .rst(rst), .issue(issue),
		.wb(wb), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [79:0] s, input logic [79:0] e);
		comparisons++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			err_count++;
		end
	endtask : chk
	task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	task automatic iss(input logic [31:0] w, input logic [31:0] t);
		@(posedge clk);
		go <= 1'b1;
		word <= w;
		src <= 32'hC0DE0001;
		tst <= t;
		fsv <= FS;
		fdv <= FD;
		@(posedge clk);
		go <= 1'b0;
		#1;
	endtask : iss
	function automatic logic [31:0] mv(input logic f, input logic [4:0] fm, input logic [2:0] c);
		// even cc only in paired form
		return f ? {FPU_MAJOR_OP, fm, c, 2'b01, 10'h085, FN_FP_MOVE_CF}
			: {SPECIAL_OP, 5'h01, c, 2'b01, 10'h060, FN_MOVE_CF};
	endfunction : mv
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// ceiling well above the hundred or fewer cycles the tests take
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		av(1'b0, REG_CTRL, 32'h0);
		chk("ctrl reset", rd, 64'(CTRL_RESET));
		av(1'b0, 8'hFC, 32'h0);
		chk("unmapped read", rd, 64'(RD_UNMAPPED));
		iss(MNZ, 32'h80000000);
		chk("int copy", {wb.gpr_we, wb.dest, wb.data[31:0]}, {6'h23, 32'hC0DE0001});
		iss(MNZ, 32'h0);
		chk("int hold", {wb.valid, wb.gpr_we}, 2'b10);
		iss(MNZ | 32'h40, 32'h1);
		chk("bad shift", wb.valid, 1'b0);
		iss(FNZ, 32'h1);
		chk("fp copy", {wb.fpr_we, wb.dest, wb.exc, wb.data},
			{6'h25, EXC_NONE, FS});
		iss(FNZ, 32'h0);
		chk("fp hold", {wb.fpr_we, wb.data}, {1'b1, FD});
		av(1'b0, REG_STATUS, 32'h0);
		chk("status", rd, 64'h28);
		av(1'b0, REG_INSTR, 32'h0);
		chk("last instr", rd, 64'(FNZ));
		$display("test nonzero moves done");
		av(1'b1, REG_CCODE, {24'h0, CC});
		for (int c = 0; c < 8; c++) begin
			iss(mv(1'b0, 5'h00, c[2:0]), 32'h0);
			chk("int true", {wb.valid, wb.gpr_we, wb.exc}, {1'b1, CC[c], EXC_NONE});
			iss(mv(1'b1, FMT_DOUBLE, c[2:0]), 32'h0);
			chk("fp true", wb.data, CC[c] ? FS : FD);
			if (c % 2 == 0) begin
				iss(mv(1'b1, FMT_PAIRED, c[2:0]), 32'h0);
				chk("paired", wb.data, {CC[c + 1] ? FS[63:32] : FD[63:32],
					CC[c] ? FS[31:0] : FD[31:0]});
			end
		end
		$display("test condition moves done");
		av(1'b1, REG_CTRL, 32'hF);
		av(1'b0, REG_CTRL, 32'h0);
		chk("ctrl write", rd, 64'hF);
		iss(MNZ, 32'h1);
		chk("release6", {wb.valid, wb.gpr_we, wb.exc}, {2'b10, EXC_RESERVED});
		av(1'b1, REG_CTRL, 32'h8);
		iss(FNZ, 32'h1);
		chk("fpu off", {wb.fpr_we, wb.exc}, {1'b0, EXC_COP_UNUSABLE});
		iss(mv(1'b0, 5'h00, 3'h1), 32'h0);
		chk("fpu off int", {wb.gpr_we, wb.exc}, {1'b0, EXC_COP_UNUSABLE});
		av(1'b1, REG_CTRL, 32'hA);
		iss(mv(1'b1, FMT_PAIRED, 3'h0), 32'h0);
		chk("narrow paired", {wb.exc, wb.undef}, {EXC_UNIMPL_OP, 1'b1});
		$display("test exceptions done");
		tally_and_finish();
	end
endmodule : tb_conditional_move_unit
